/* hdl/cpu_addr_gen_pkg.sv */
// Types for the CPU address generation block.
// Assumes nothing of its surroundings.
package cpu_addr_gen_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_MIDDLE = 2'b01, MODE_ADVANCED = 2'b10, MODE_MAXIMUM = 2'b11
  } cpu_mode_t;
  typedef enum logic [3:0] {
    EA_ABS8 = 4'h0, EA_ABS16 = 4'h1, EA_ABS24 = 4'h2, EA_ABS32 = 4'h3,
    EA_PCREL8 = 4'h4, EA_PCREL16 = 4'h5, EA_PCIDX = 4'h6, EA_MEMIND = 4'h7,
    EA_EXTIND = 4'h8, EA_ADDRLOAD = 4'h9, EA_REGIND = 4'ha, EA_PROG32 = 4'hb
  } ea_mode_t;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000, ST_EXCEPTION = 3'b001, ST_EXECUTE = 3'b010,
    ST_BUS_RELEASED = 3'b011, ST_STOPPED = 3'b100, ST_FETCH_PTR = 3'b101
  } proc_state_t;
endpackage : cpu_addr_gen_pkg

/* hdl/cpu_addr_gen_regs.svh */
// Constants for the CPU address generation and processing-state block.
// Assumes inclusion by bare name from the design files.
`ifndef CPU_ADDR_GEN_REGS_SVH
`define CPU_ADDR_GEN_REGS_SVH
`define EXT_VEC_OFFSET 8'h80
`define SHORT_ABS_MASK 32'h0000_00ff
`define PROG24_MASK 32'h00ff_ffff
`define NORMAL16_MASK 32'h0000_ffff
`define RESET_VECTOR 32'h0000_0000
`define ADDR_ERR_VECTOR 32'h0000_0004
`define VEC_SCALE_SHIFT 2
`endif

/* hdl/cpu_address_generation.sv */
// Address generation and processing-state control of the CPU core.
// Assumes a memory port answering reads with a one-cycle-or-more valid,
// and a decoder presenting one addressing request at a time.
`timescale 1ns/100ps
`include "cpu_addr_gen_regs.svh"

module cpu_address_generation #(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic external_reset_n_i,
  input wire logic watchdog_overflow_i,
  input wire cpu_addr_gen_pkg::cpu_mode_t cpu_mode_i,
  input wire logic ea_req_i,
  input wire cpu_addr_gen_pkg::ea_mode_t ea_mode_i,
  input wire logic [31:0] ea_field_i,
  input wire logic [31:0] ea_reg_i,
  input wire logic [2:0] ea_reg_num_i,
  input wire logic [1:0] idx_size_i,
  input wire logic [1:0] op_size_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] short_address_base_reg_i,
  input wire logic [31:0] vector_base_reg_i,
  input wire logic reg_update_i,
  input wire logic [2:0] reg_update_num_i,
  input wire logic [31:0] reg_update_val_i,
  input wire logic [31:0] imm_i,
  input wire logic [1:0] imm_width_i,
  input wire logic [15:0] opcode_i,
  input wire logic exc_req_i,
  input wire logic [7:0] exc_vector_i,
  input wire logic sleep_i,
  input wire logic standby_i,
  input wire logic wake_i,
  input wire logic bus_req_i,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_rdata_i,
  output logic ea_valid_o,
  output logic [ADDR_W-1:0] ea_o,
  output logic reg_write_o,
  output logic [2:0] reg_write_num_o,
  output logic [31:0] imm_ext_o,
  output logic [2:0] bit_number_o,
  output logic [7:0] bit_field_o,
  output logic [1:0] trap_vector_o,
  output logic mem_read_o,
  output logic [31:0] mem_addr_o,
  output logic mem_long_o,
  output logic bus_grant_o,
  output logic cpu_halted_o,
  output logic interrupts_masked_o,
  output logic periph_reset_o,
  output logic branch_o,
  output logic [31:0] branch_addr_o,
  output cpu_addr_gen_pkg::proc_state_t state_o
);
  // ==========================================================
  // Reset pin synchroniser
  // ==========================================================
  logic [2:0] res_sync;
  logic [2:0] next_res_sync;
  logic res_level;
  logic next_res_level;
  // Three stages; level changes when last two agree
  always_comb begin
    next_res_sync = {res_sync[1:0], external_reset_n_i};
    next_res_level = res_level;
    if (res_sync[2] == res_sync[1]) begin
      next_res_level = res_sync[2];
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_sync <= 3'h0;
      res_level <= 1'b0;
    end else begin
      res_sync <= next_res_sync;
      res_level <= next_res_level;
    end
  end

  // ==========================================================
  // Address calculator
  // ==========================================================
  logic [31:0] calc_ea;
  logic calc_branch;
  logic [31:0] calc_reg;
  logic [31:0] calc_field;
  cpu_addr_gen_pkg::ea_mode_t calc_mode;
  ea_calc u_ea_calc (
    .mode_i(calc_mode),
    .cpu_mode_i(cpu_mode_i),
    .field_i(calc_field),
    .reg_i(calc_reg),
    .idx_size_i(idx_size_i),
    .op_size_i(op_size_i),
    .next_pc_i(next_pc_i),
    .short_address_base_reg_i(short_address_base_reg_i),
    .ea_o(calc_ea),
    .is_branch_o(calc_branch)
  );

  // ==========================================================
  // Processing state machine
  // ==========================================================
  cpu_addr_gen_pkg::proc_state_t state;
  cpu_addr_gen_pkg::proc_state_t next_state;
  cpu_addr_gen_pkg::ea_mode_t pend_mode;
  cpu_addr_gen_pkg::ea_mode_t next_pend_mode;
  logic [31:0] pend_field;
  logic [31:0] next_pend_field;
  logic [2:0] pend_reg_num;
  logic [2:0] next_pend_reg_num;
  logic pend_exc;
  logic next_pend_exc;
  logic [31:0] mem_addr;
  logic [31:0] next_mem_addr;
  logic mem_long;
  logic next_mem_long;
  logic ea_valid;
  logic next_ea_valid;
  logic [31:0] ea;
  logic [31:0] next_ea;
  logic reg_write;
  logic next_reg_write;
  logic branch;
  logic next_branch;
  logic [31:0] branch_addr;
  logic [31:0] next_branch_addr;
  logic [31:0] fwd_reg;
  logic [31:0] vec_addr;
  logic [31:0] ptr_val;

  // Forward a same-cycle register update into the calculation
  always_comb begin
    fwd_reg = ea_reg_i;
    if (reg_update_i && reg_update_num_i == ea_reg_num_i) begin
      fwd_reg = reg_update_val_i;
    end
  end

  // Vector address, relocated except reset and address error
  always_comb begin
    vec_addr = {22'h0, exc_vector_i, 2'b00};
    if (vec_addr != `RESET_VECTOR && vec_addr != `ADDR_ERR_VECTOR) begin
      vec_addr = vector_base_reg_i + vec_addr;
    end
  end

  // Pointer fetched from memory, trimmed per mode
  always_comb begin
    if (cpu_mode_i == cpu_addr_gen_pkg::MODE_NORMAL) begin
      ptr_val = {16'h0000, mem_rdata_i[15:0]};
    end else if (cpu_mode_i == cpu_addr_gen_pkg::MODE_MAXIMUM) begin
      ptr_val = mem_rdata_i;
    end else begin
      ptr_val = {8'h00, mem_rdata_i[23:0]};
    end
  end

  // Calculator input select: live request or pending second step
  always_comb begin
    calc_mode = ea_mode_i;
    calc_field = ea_field_i;
    calc_reg = fwd_reg;
    if (state == cpu_addr_gen_pkg::ST_FETCH_PTR) begin
      calc_mode = cpu_addr_gen_pkg::EA_ADDRLOAD;
      calc_field = pend_field;
      calc_reg = mem_rdata_i;
    end
  end

  // Next-state and output decisions
  always_comb begin
    next_state = state;
    next_pend_mode = pend_mode;
    next_pend_field = pend_field;
    next_pend_reg_num = pend_reg_num;
    next_pend_exc = pend_exc;
    next_mem_addr = mem_addr;
    next_mem_long = mem_long;
    next_ea_valid = 1'b0;
    next_ea = ea;
    next_reg_write = 1'b0;
    next_branch = 1'b0;
    next_branch_addr = branch_addr;
    if (!res_level || watchdog_overflow_i) begin
      next_state = cpu_addr_gen_pkg::ST_RESET;
    end else begin
      case (state)
        cpu_addr_gen_pkg::ST_RESET: begin
          // Release starts reset exception handling
          next_state = cpu_addr_gen_pkg::ST_EXCEPTION;
          next_mem_addr = `RESET_VECTOR;
          next_mem_long = 1'b1;
          next_pend_exc = 1'b1;
        end
        cpu_addr_gen_pkg::ST_EXCEPTION: begin
          if (bus_req_i) begin
            next_state = cpu_addr_gen_pkg::ST_BUS_RELEASED;
          end else if (mem_valid_i) begin
            // Vector fetched; branch and resume
            next_branch = 1'b1;
            next_branch_addr = ptr_val;
            next_pend_exc = 1'b0;
            next_state = cpu_addr_gen_pkg::ST_EXECUTE;
          end
        end
        cpu_addr_gen_pkg::ST_EXECUTE: begin
          if (bus_req_i) begin
            next_state = cpu_addr_gen_pkg::ST_BUS_RELEASED;
          end else if (sleep_i || standby_i) begin
            next_state = cpu_addr_gen_pkg::ST_STOPPED;
          end else if (exc_req_i) begin
            next_state = cpu_addr_gen_pkg::ST_EXCEPTION;
            next_mem_addr = vec_addr;
            next_mem_long = 1'b1;
            next_pend_exc = 1'b1;
          end else if (ea_req_i) begin
            if (ea_mode_i == cpu_addr_gen_pkg::EA_MEMIND ||
                ea_mode_i == cpu_addr_gen_pkg::EA_EXTIND ||
                ea_mode_i == cpu_addr_gen_pkg::EA_ADDRLOAD) begin
              // Two-step modes read memory first
              next_state = cpu_addr_gen_pkg::ST_FETCH_PTR;
              next_pend_mode = ea_mode_i;
              next_pend_field = ea_field_i;
              next_pend_reg_num = ea_reg_num_i;
              next_pend_exc = 1'b0;
              if (ea_mode_i == cpu_addr_gen_pkg::EA_ADDRLOAD) begin
                next_mem_addr = fwd_reg;
                next_mem_long = (idx_size_i == 2'd2);
              end else begin
                next_mem_addr = calc_ea;
                next_mem_long = (cpu_mode_i != cpu_addr_gen_pkg::MODE_NORMAL);
              end
            end else begin
              next_ea_valid = 1'b1;
              next_ea = calc_ea;
              if (calc_branch) begin
                next_branch = 1'b1;
                next_branch_addr = calc_ea;
              end
            end
          end
        end
        cpu_addr_gen_pkg::ST_FETCH_PTR: begin
          if (mem_valid_i) begin
            next_state = cpu_addr_gen_pkg::ST_EXECUTE;
            if (pend_mode == cpu_addr_gen_pkg::EA_ADDRLOAD) begin
              next_ea = calc_ea;
              next_ea_valid = 1'b1;
              next_reg_write = 1'b1;
            end else begin
              next_branch = 1'b1;
              next_branch_addr = ptr_val;
            end
          end
        end
        cpu_addr_gen_pkg::ST_BUS_RELEASED: begin
          if (!bus_req_i) begin
            // Resume where halted
            next_state = pend_exc ? cpu_addr_gen_pkg::ST_EXCEPTION
                                  : cpu_addr_gen_pkg::ST_EXECUTE;
          end
        end
        cpu_addr_gen_pkg::ST_STOPPED: begin
          if (wake_i && !standby_i) begin
            next_state = cpu_addr_gen_pkg::ST_EXECUTE;
          end
        end
        default: next_state = cpu_addr_gen_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= cpu_addr_gen_pkg::ST_RESET;
      pend_mode <= cpu_addr_gen_pkg::EA_ABS32;
      pend_field <= 32'h0;
      pend_reg_num <= 3'h0;
      pend_exc <= 1'b0;
      mem_addr <= 32'h0;
      mem_long <= 1'b0;
      ea_valid <= 1'b0;
      ea <= 32'h0;
      reg_write <= 1'b0;
      branch <= 1'b0;
      branch_addr <= 32'h0;
    end else begin
      state <= next_state;
      pend_mode <= next_pend_mode;
      pend_field <= next_pend_field;
      pend_reg_num <= next_pend_reg_num;
      pend_exc <= next_pend_exc;
      mem_addr <= next_mem_addr;
      mem_long <= next_mem_long;
      ea_valid <= next_ea_valid;
      ea <= next_ea;
      reg_write <= next_reg_write;
      branch <= next_branch;
      branch_addr <= next_branch_addr;
    end
  end

  // ==========================================================
  // Immediate decode
  // ==========================================================
  logic [31:0] imm_ext;
  logic [31:0] next_imm_ext;
  logic [2:0] bit_number;
  logic [7:0] bit_field;
  logic [1:0] trap_vector;
  // Zero-extend by source width; pick embedded fields
  always_comb begin
    case (imm_width_i)
      2'd0: next_imm_ext = {29'h0, imm_i[2:0]};
      2'd1: next_imm_ext = {24'h0, imm_i[7:0]};
      2'd2: next_imm_ext = {16'h0, imm_i[15:0]};
      default: next_imm_ext = imm_i;
    endcase
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      imm_ext <= 32'h0;
      bit_number <= 3'h0;
      bit_field <= 8'h0;
      trap_vector <= 2'h0;
    end else begin
      imm_ext <= next_imm_ext;
      bit_number <= opcode_i[6:4];
      bit_field <= opcode_i[7:0];
      trap_vector <= opcode_i[5:4];
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign state_o = state;
  assign ea_valid_o = ea_valid;
  assign ea_o = ea[ADDR_W-1:0];
  assign reg_write_o = reg_write;
  assign reg_write_num_o = pend_reg_num;
  assign imm_ext_o = imm_ext;
  assign bit_number_o = bit_number;
  assign bit_field_o = bit_field;
  assign trap_vector_o = trap_vector;
  assign mem_read_o = (state == cpu_addr_gen_pkg::ST_FETCH_PTR) ||
                      (state == cpu_addr_gen_pkg::ST_EXCEPTION);
  assign mem_addr_o = mem_addr;
  assign mem_long_o = mem_long;
  assign bus_grant_o = (state == cpu_addr_gen_pkg::ST_BUS_RELEASED);
  assign cpu_halted_o = (state == cpu_addr_gen_pkg::ST_BUS_RELEASED) ||
                        (state == cpu_addr_gen_pkg::ST_STOPPED) ||
                        (state == cpu_addr_gen_pkg::ST_RESET);
  assign interrupts_masked_o = (state == cpu_addr_gen_pkg::ST_RESET);
  assign periph_reset_o = (state == cpu_addr_gen_pkg::ST_RESET);
  assign branch_o = branch;
  assign branch_addr_o = branch_addr;
endmodule : cpu_address_generation

/* hdl/ea_calc.sv */
// Combinational effective-address calculator.
// Assumes operands are stable while mode_i selects a calculation.
`timescale 1ns/100ps
`include "cpu_addr_gen_regs.svh"
module ea_calc (
  input wire cpu_addr_gen_pkg::ea_mode_t mode_i,
  input wire cpu_addr_gen_pkg::cpu_mode_t cpu_mode_i,
  input wire logic [31:0] field_i,
  input wire logic [31:0] reg_i,
  input wire logic [1:0] idx_size_i,
  input wire logic [1:0] op_size_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] short_address_base_reg_i,
  output logic [31:0] ea_o,
  output logic is_branch_o
);
  logic [31:0] raw;
  logic [31:0] idx;
  logic [8:0] vec_sum;
  // Zero-extend the selected index size
  always_comb begin
    case (idx_size_i)
      2'd0: idx = {24'h000000, reg_i[7:0]};
      2'd1: idx = {16'h0000, reg_i[15:0]};
      default: idx = reg_i;
    endcase
  end
  // Raw address per addressing mode
  always_comb begin
    vec_sum = {2'b00, field_i[6:0]} + {1'b0, `EXT_VEC_OFFSET};
    is_branch_o = 1'b0;
    raw = field_i;
    case (mode_i)
      cpu_addr_gen_pkg::EA_ABS8:
        raw = (short_address_base_reg_i & ~`SHORT_ABS_MASK) | (field_i & `SHORT_ABS_MASK);
      cpu_addr_gen_pkg::EA_ABS16: raw = {{16{field_i[15]}}, field_i[15:0]};
      cpu_addr_gen_pkg::EA_ABS24: begin
        raw = field_i & `PROG24_MASK;
        is_branch_o = 1'b1;
      end
      cpu_addr_gen_pkg::EA_ABS32: raw = field_i;
      cpu_addr_gen_pkg::EA_PROG32: begin
        raw = field_i;
        is_branch_o = 1'b1;
      end
      cpu_addr_gen_pkg::EA_PCREL8: begin
        raw = next_pc_i + {{24{field_i[7]}}, field_i[7:0]};
        is_branch_o = 1'b1;
      end
      cpu_addr_gen_pkg::EA_PCREL16: begin
        raw = next_pc_i + {{16{field_i[15]}}, field_i[15:0]};
        is_branch_o = 1'b1;
      end
      cpu_addr_gen_pkg::EA_PCIDX: begin
        raw = next_pc_i + {idx[30:0], 1'b0};
        is_branch_o = 1'b1;
      end
      cpu_addr_gen_pkg::EA_MEMIND: raw = field_i & `SHORT_ABS_MASK;
      cpu_addr_gen_pkg::EA_EXTIND: begin
        // Word pointers scale by two, longwords by four
        if (cpu_mode_i == cpu_addr_gen_pkg::MODE_NORMAL) begin
          raw = {22'h0, vec_sum, 1'b0};
        end else begin
          raw = {21'h0, vec_sum, 2'b00};
        end
      end
      cpu_addr_gen_pkg::EA_ADDRLOAD: begin
        // Fetched operand scaled by size plus displacement
        case (op_size_i)
          2'd1: raw = field_i + {idx[30:0], 1'b0};
          2'd2: raw = field_i + {idx[29:0], 2'b00};
          default: raw = field_i + idx;
        endcase
      end
      cpu_addr_gen_pkg::EA_REGIND: raw = reg_i;
      default: raw = field_i;
    endcase
  end
  // Operating-mode masking of the result
  always_comb begin
    ea_o = raw;
    case (cpu_mode_i)
      cpu_addr_gen_pkg::MODE_NORMAL: ea_o = raw & `NORMAL16_MASK;
      cpu_addr_gen_pkg::MODE_MIDDLE: begin
        if (is_branch_o) begin
          ea_o = raw & `PROG24_MASK;
        end else begin
          ea_o = {{16{raw[15]}}, raw[15:0]};
        end
      end
      cpu_addr_gen_pkg::MODE_ADVANCED: begin
        if (is_branch_o) begin
          ea_o = raw & `PROG24_MASK;
        end
      end
      default: ea_o = raw;
    endcase
  end
endmodule : ea_calc

/* test/cpu_addr_gen_chk.sv */
// Port checker for the address generation block.
// Assumes binding onto cpu_address_generation, one clock domain.
`timescale 1ns/100ps
module cpu_addr_gen_chk #(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic external_reset_n_i,
  input wire cpu_addr_gen_pkg::cpu_mode_t cpu_mode_i,
  input wire logic ea_req_i,
  input wire cpu_addr_gen_pkg::ea_mode_t ea_mode_i,
  input wire logic [31:0] ea_field_i,
  input wire logic [31:0] short_address_base_reg_i,
  input wire logic [31:0] vector_base_reg_i,
  input wire logic exc_req_i,
  input wire logic [7:0] exc_vector_i,
  input wire logic sleep_i,
  input wire logic standby_i,
  input wire logic bus_req_i,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic ea_valid_o,
  input wire logic [ADDR_W-1:0] ea_o,
  input wire logic mem_read_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic bus_grant_o,
  input wire logic cpu_halted_o,
  input wire logic interrupts_masked_o,
  input wire logic periph_reset_o,
  input wire logic branch_o,
  input wire logic [31:0] branch_addr_o,
  input wire cpu_addr_gen_pkg::proc_state_t state_o
);
  logic run;
  logic take;
  logic maxm;
  // Accepted request in execute state
  assign run = state_o == cpu_addr_gen_pkg::ST_EXECUTE;
  assign take = run && ea_req_i && !bus_req_i && !sleep_i && !standby_i && !exc_req_i;
  assign maxm = cpu_mode_i == cpu_addr_gen_pkg::MODE_MAXIMUM;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Two-step pointer fetch
  sequence ptr_issue;
    take && ea_mode_i == cpu_addr_gen_pkg::EA_MEMIND ##1
      state_o == cpu_addr_gen_pkg::ST_FETCH_PTR;
  endsequence
  ptr_range_a: assert property (ptr_issue |-> mem_read_o && mem_addr_o[31:8] == 24'h0)
    else $error("pointer fetch outside first page");
  // ==========================================
  // Absolute forms
  abs_short_a: assert property (take && ea_mode_i == cpu_addr_gen_pkg::EA_ABS8 && maxm
    |=> ea_valid_o && ea_o == {$past(short_address_base_reg_i[31:8]), $past(ea_field_i[7:0])})
    else $error("short absolute address wrong");
  abs_word_a: assert property (take && ea_mode_i == cpu_addr_gen_pkg::EA_ABS16 && maxm
    |=> ea_valid_o && ea_o == {{16{$past(ea_field_i[15])}}, $past(ea_field_i[15:0])})
    else $error("word absolute not sign-extended");
  // ==========================================
  // Processing states
  reset_hold_a: assert property (state_o == cpu_addr_gen_pkg::ST_RESET
    |-> cpu_halted_o && interrupts_masked_o && periph_reset_o && !mem_read_o)
    else $error("reset state outputs wrong");
  pin_reset_a: assert property (!external_reset_n_i
    |-> ##[1:5] state_o == cpu_addr_gen_pkg::ST_RESET)
    else $error("reset pin not obeyed");
  vec_reloc_a: assert property (run && exc_req_i && !bus_req_i && !sleep_i && !standby_i
    |=> state_o == cpu_addr_gen_pkg::ST_EXCEPTION && mem_addr_o ==
      (($past(exc_vector_i) < 8'h02) ? 32'h0 : $past(vector_base_reg_i))
      + {22'h0, $past(exc_vector_i), 2'h0})
    else $error("vector address wrong");
  exc_branch_a: assert property (state_o == cpu_addr_gen_pkg::ST_EXCEPTION
    && mem_valid_i && maxm |=> branch_o && branch_addr_o == $past(mem_rdata_i))
    else $error("exception did not branch to vector");
  bus_grant_a: assert property (run && bus_req_i |=> bus_grant_o && cpu_halted_o)
    else $error("bus not released");
  bus_halt_a: assert property (bus_grant_o && bus_req_i
    |=> bus_grant_o && !ea_valid_o && !branch_o)
    else $error("activity while bus released");
  sleep_stop_a: assert property (run && sleep_i && !bus_req_i
    |=> state_o == cpu_addr_gen_pkg::ST_STOPPED && cpu_halted_o)
    else $error("sleep did not stop");
endmodule : cpu_addr_gen_chk

bind cpu_address_generation cpu_addr_gen_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

/* test/mem_model.sv */
// Memory responder standing for the internal bus.
// Assumes the read request is held until its valid pulse is taken.
`timescale 1ns/100ps
module mem_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic mem_read_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic slow_i,
  output logic mem_valid_o,
  output logic [31:0] mem_rdata_o
);
  logic [2:0] wait_cnt;
  // Answer after one or four cycles; data toggles when idle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 3'h0;
      mem_valid_o <= 1'b0;
      mem_rdata_o <= 32'h0;
    end else if (mem_valid_o || !mem_read_i) begin
      wait_cnt <= 3'h0;
      mem_valid_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (wait_cnt == (slow_i ? 3'h3 : 3'h0)) begin
      mem_valid_o <= 1'b1;
      mem_rdata_o <= {~mem_addr_i[15:0], mem_addr_i[15:0] ^ 16'ha5c3};
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule : mem_model

/* test/test_cpu_address_generation.sv */
// Self-checking bench of the address generation block.
// Assumes the memory responder and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_cpu_address_generation;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, external_reset_n_i = 1'b0, watchdog_overflow_i = 1'b0;
  logic ea_req_i = 1'b0, sleep_i = 1'b0, standby_i = 1'b0, wake_i = 1'b0, slow = 1'b0;
  logic bus_req_i = 1'b0, exc_req_i = 1'b0, mem_valid_i, reg_update_i = 1'b0;
  cpu_addr_gen_pkg::cpu_mode_t cpu_mode_i = cpu_addr_gen_pkg::MODE_MAXIMUM;
  cpu_addr_gen_pkg::ea_mode_t ea_mode_i = cpu_addr_gen_pkg::EA_ABS32;
  logic [31:0] ea_field_i = 32'h0, ea_reg_i = 32'h1ff, next_pc_i = 32'h1000, imm_i = 32'h0;
  logic [31:0] short_address_base_reg_i = 32'h12345600, vector_base_reg_i = 32'h1000;
  logic [1:0] idx_size_i = 2'h0, imm_width_i = 2'h0;
  logic [15:0] opcode_i = 16'h1e6b;
  logic [7:0] exc_vector_i = 8'h0;
  logic ea_valid_o, reg_write_o, mem_read_o, mem_long_o, bus_grant_o, cpu_halted_o;
  logic interrupts_masked_o, periph_reset_o, branch_o;
  logic [31:0] ea_o, imm_ext_o, mem_addr_o, branch_addr_o, mem_rdata_i, reg_update_val_i;
  logic [2:0] bit_number_o, reg_write_num_o, reg_update_num_i, ea_reg_num_i;
  logic [7:0] bit_field_o;
  logic [1:0] trap_vector_o;
  cpu_addr_gen_pkg::proc_state_t state_o;
  int errors = 0, n_compared = 0;
  // ==========================================
  // Clock, block and memory
  always #25 ref_clk_i = ~ref_clk_i;
  cpu_address_generation #(.ADDR_W(32)) i_dut (.op_size_i(2'h2), .*);
  mem_model i_mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_read_i(mem_read_o),
    .mem_addr_i(mem_addr_o), .slow_i(slow), .mem_valid_o(mem_valid_i),
    .mem_rdata_o(mem_rdata_i));
  // ==========================================
  // Shared tasks
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : step
  task automatic wait_for(input bit pulse, input logic [2:0] s);
    for (int i = 0; i < 40; i++) begin
      if (pulse ? (branch_o | ea_valid_o) === 1'b1 : state_o === s) return;
      step();
    end
    errors++;
    give_verdict();
  endtask : wait_for
  task automatic req(input logic [3:0] m, input logic [31:0] f);
    ea_mode_i = cpu_addr_gen_pkg::ea_mode_t'(m);
    ea_field_i = f;
    ea_req_i = 1'b1;
    step();
    ea_req_i = 1'b0;
  endtask : req
  // ==========================================
  // Scenarios
  task automatic t_reset;
    `CHK("reset outputs", 3'h7, {cpu_halted_o, interrupts_masked_o, periph_reset_o})
    external_reset_n_i = 1'b1;
    wait_for(0, 3'h1);
    `CHK("reset vector", 32'h0, mem_addr_o)
    wait_for(1, 3'h0);
    `CHK("reset branch", 32'hffffa5c3, branch_addr_o)
    watchdog_overflow_i = 1'b1;
    step(2);
    `CHK("watchdog", 3'h0, state_o)
    watchdog_overflow_i = 1'b0;
    wait_for(0, 3'h2);
    external_reset_n_i = 1'b0;
    step(5);
    `CHK("pin low", 4'h1, {state_o, cpu_halted_o})
    external_reset_n_i = 1'b1;
    wait_for(0, 3'h2);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_direct;
    logic [1:0] cm[10] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h0};
    logic [3:0] md[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'hb, 4'h4, 4'h5, 4'h6, 4'ha};
    logic [31:0] fl[10] = '{32'ha5, 32'h8000, 32'hab123456, 32'hdeadbeef, 32'h18000,
      32'hab123456, 32'h80, 32'h8000, 32'h0, 32'h0};
    logic [31:0] ex[10] = '{32'h123456a5, 32'hffff8000, 32'h123456, 32'hdeadbeef,
      32'hffff8000, 32'h123456, 32'hf80, 32'hff9000, 32'h11fe, 32'h1ff};
    ea_req_i = 1'b1;
    for (int i = 0; i < 10; i++) begin
      cpu_mode_i = cpu_addr_gen_pkg::cpu_mode_t'(cm[i]);
      ea_mode_i = cpu_addr_gen_pkg::ea_mode_t'(md[i]);
      ea_field_i = fl[i];
      step();
      `CHK("direct ea", {1'b1, ex[i]}, {ea_valid_o, ea_o})
    end
    ea_req_i = 1'b0;
    $display("t_direct done");
  endtask : t_direct
  task automatic t_ptr;
    logic [1:0] cm[5] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h3};
    logic [3:0] md[5] = '{4'h7, 4'h8, 4'h8, 4'h7, 4'h9};
    logic [31:0] fl[5] = '{32'h1234, 32'h7f, 32'h1, 32'hff, 32'h100};
    logic [31:0] ad[5] = '{32'h34, 32'h3fc, 32'h102, 32'hff, 32'h40};
    logic [31:0] ex[5] = '{32'ha5f7, 32'h3a63f, 32'ha4c1, 32'hff00a53c, 32'hfefe970c};
    idx_size_i = 2'h2;
    {reg_update_i, reg_update_num_i, ea_reg_num_i, reg_update_val_i} = {7'h5b, 32'h40};
    for (int i = 0; i < 5; i++) begin
      cpu_mode_i = cpu_addr_gen_pkg::cpu_mode_t'(cm[i]);
      slow = i[0];
      req(md[i], fl[i]);
      `CHK("ptr fetch", {3'h5, 1'b1, ad[i]}, {state_o, mem_read_o, mem_addr_o})
      `CHK("ptr long", cm[i] != 2'h0, mem_long_o)
      wait_for(1, 3'h0);
      `CHK("ptr result", ex[i], (md[i] == 4'h9) ? ea_o : branch_addr_o)
    end
    `CHK("load writes", 4'hb, {reg_write_o, reg_write_num_o})
    reg_update_i = 1'b0;
    cpu_mode_i = cpu_addr_gen_pkg::MODE_MAXIMUM;
    $display("t_ptr done");
  endtask : t_ptr
  task automatic t_exc;
    logic [7:0] vn[2] = '{8'h5, 8'h1};
    logic [31:0] ad[2] = '{32'h1014, 32'h4};
    logic [31:0] ex[2] = '{32'hefebb5d7, 32'hfffba5c7};
    for (int i = 0; i < 2; i++) begin
      exc_vector_i = vn[i];
      exc_req_i = 1'b1;
      step();
      exc_req_i = 1'b0;
      `CHK("vector addr", {3'h1, ad[i]}, {state_o, mem_addr_o})
      wait_for(1, 3'h0);
      `CHK("vector branch", ex[i], branch_addr_o)
      wait_for(0, 3'h2);
    end
    $display("t_exc done");
  endtask : t_exc
  task automatic t_bus;
    bus_req_i = 1'b1;
    step();
    `CHK("grant", 2'h3, {bus_grant_o, cpu_halted_o})
    req(4'h3, 32'h5);
    step(3);
    `CHK("halted ea", 1'b0, ea_valid_o)
    bus_req_i = 1'b0;
    wait_for(0, 3'h2);
    `CHK("returned", 1'b0, bus_grant_o)
    $display("t_bus done");
  endtask : t_bus
  task automatic t_stop;
    sleep_i = 1'b1;
    step();
    sleep_i = 1'b0;
    `CHK("sleep", 4'h9, {state_o, cpu_halted_o})
    wake_i = 1'b1;
    step();
    wake_i = 1'b0;
    wait_for(0, 3'h2);
    standby_i = 1'b1;
    step();
    wake_i = 1'b1;
    step();
    wake_i = 1'b0;
    `CHK("standby", 3'h4, state_o)
    standby_i = 1'b0;
    wake_i = 1'b1;
    step();
    wake_i = 1'b0;
    wait_for(0, 3'h2);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_imm;
    logic [31:0] ex[4] = '{32'h5, 32'hf5, 32'hfff5, 32'hfffffff5};
    imm_i = 32'hfffffff5;
    for (int w = 0; w < 4; w++) begin
      imm_width_i = w[1:0];
      step();
      `CHK("imm ext", ex[w], imm_ext_o)
    end
    `CHK("decode", {3'h6, 8'h6b, 2'h2}, {bit_number_o, bit_field_o, trap_vector_o})
    $display("t_imm done");
  endtask : t_imm
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #2;
    rst_i = 1'b0;
    step();
    t_reset();
    t_direct();
    t_ptr();
    t_exc();
    t_bus();
    t_stop();
    t_imm();
    give_verdict();
  end
endmodule : test_cpu_address_generation
